// >>> shared/ptm_pkg.sv
package ptm_pkg;

  // Array sizes
  localparam int unsigned NUM_IN  = 32;
  localparam int unsigned NUM_FB  = 9;
  localparam int unsigned NUM_MC  = 16;
  localparam int unsigned NUM_PT  = 32;
  localparam int unsigned PT_W    = 41;
  localparam int unsigned MEM_AW  = 4;
  localparam int unsigned MEM_DW  = 16;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STAT    = 12'h004;
  localparam logic [11:0] OFS_MC_BASE = 12'h100;
  localparam logic [11:0] OFS_PT_BASE = 12'h200;

  // Control word fields
  localparam int unsigned CTRL_MEM_BIT      = 0;
  localparam int unsigned CTRL_OREG_BIT     = 1;
  localparam int unsigned CTRL_FALL_LSB     = 2;
  localparam int unsigned CTRL_CLR_INV_LSB  = 4;
  localparam int unsigned CTRL_CLR_LCL_LSB  = 6;
  localparam int unsigned CTRL_CLK_SRC_LSB  = 8;
  localparam logic [31:0] CTRL_RST          = 32'h0000_0000;

  // Status word fields
  localparam int unsigned STAT_MEM_BIT = 16;

  // Macrocell configuration word fields
  localparam int unsigned MC_LEND0_BIT  = 0;
  localparam int unsigned MC_LEND1_BIT  = 1;
  localparam int unsigned MC_INV1_BIT   = 2;
  localparam int unsigned MC_TYPE_LSB   = 3;
  localparam int unsigned MC_BYP_BIT    = 5;
  localparam int unsigned MC_CLK_BIT    = 6;
  localparam int unsigned MC_CLR_LSB    = 7;
  localparam int unsigned MC_XOR_BIT    = 9;
  localparam int unsigned MC_BORROW_LSB = 16;
  localparam logic [31:0] MC_RST        = 32'h0000_0020;
  localparam logic [PT_W-1:0] PT_RST    = 41'h000_0000_0000;

  // Memory mode use of the logic inputs
  localparam int unsigned MEM_WA_LSB = 0;
  localparam int unsigned MEM_RA_LSB = 4;
  localparam int unsigned MEM_WD_LSB = 8;
  localparam int unsigned MEM_WE_BIT = 24;

  // Control line positions
  localparam int unsigned LCL_CLK_LSB = 0;
  localparam int unsigned LCL_EN_LSB  = 2;
  localparam int unsigned LCL_CLR_LSB = 4;
  localparam int unsigned GLB_CLK_LSB = 0;
  localparam int unsigned GLB_CLR_LSB = 2;

  typedef enum logic [1:0] {
    FF_D  = 2'b00,
    FF_T  = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } ptm_ff_e;

  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_GLB = 2'b01,
    SRC_LCL = 2'b10
  } ptm_src_e;

  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_ZERO = 2'b01,
    CLR_ONE  = 2'b10
  } ptm_clr_e;

endpackage : ptm_pkg

// >>> hw/ptm_mc_reg.sv
`timescale 1ns/1ps
module ptm_mc_reg
  import ptm_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // Control
  input  wire logic tick_i,
  input  wire logic clr_i,
  input  wire logic [1:0] ff_type_i,
  // Data
  input  wire logic d_i,
  input  wire logic aux_i,
  output logic      q_o
);

  logic q_reg;
  logic q_next;

  ////////////////////////////////////////////////////////////////////////
  // R8: register type
  always_comb begin
    case (ptm_ff_e'(ff_type_i))
      FF_D:    q_next = d_i;
      FF_T:    q_next = q_reg ^ d_i;
      FF_JK:   q_next = (d_i & ~q_reg) | (~aux_i & q_reg);
      // Reset wins when set and reset are both high
      FF_SR:   q_next = (d_i | q_reg) & ~aux_i;
      default: q_next = q_reg;
    endcase
  end

  // R14: clear before tick
  // R19: hold without tick
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_reg <= 1'b0;
    end else if (clr_i) begin
      q_reg <= 1'b0;
    end else if (tick_i) begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

  ////////////////////////////////////////////////////////////////////////
  property p_hold;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      !tick_i && !clr_i |=> $stable(q_reg);
  endproperty
  a_hold: assert property (p_hold) // R19
    else $error("register changed without a tick");

  property p_clear;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      clr_i |=> !q_reg;
  endproperty
  a_clear: assert property (p_clear) // R14
    else $error("clear did not zero the register");

  property p_dtype;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      tick_i && !clr_i && ff_type_i == FF_D |=> q_reg == $past(d_i);
  endproperty
  a_dtype: assert property (p_dtype) // R8
    else $error("D register did not load its input");

  property p_ttype;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      tick_i && !clr_i && ff_type_i == FF_T && d_i
        |=> q_reg != $past(q_reg);
  endproperty
  a_ttype: assert property (p_ttype) // R8
    else $error("T register did not toggle");

endmodule : ptm_mc_reg

// >>> hw/ptm_macrocell_array.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Control bit selects memory or macrocell operation
// R2: Thirty-two logic inputs from local routing
// R3: Nine macrocell outputs fed back as inputs
// R4: Sixteen macrocells in product-term operation
// R5: Two product terms, one register per macrocell
// R6: Each term primary input or lent expander
// R7: Second product term per macrocell may invert
// R8: Register acts as D, T, JK or SR
// R9: Bypass gives purely combinational macrocell output; the code still registers it in mc_out_reg on clk_sys_i
// R10: Two block clocks, each from three sources
// R11: Each block clock gated by its enable
// R12: Each block clock picks its own edge
// R13: Two clears from global or local, invertible
// R14: Each macrocell picks clear zero, one, none
// R15: Up to thirty borrowed terms feed OR
// R16: Borrowing in sets of two per neighbour
// R17: Memory registers inputs, optional output register
// R18: Memory reads and writes on separate clocks
// R19: Disabled clock enable holds the register
module ptm_macrocell_array
  import ptm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // APB slave
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [11:0]  paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic      [31:0]  prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  // Logic inputs and control lines
  input  wire logic [31:0]  lgc_in_i,
  input  wire logic [1:0]   ded_clk_i,
  input  wire logic [3:0]   glb_sig_i,
  input  wire logic [5:0]   lcl_ctrl_i,
  // Macrocell outputs
  output logic      [15:0]  mc_out_o
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_reg;
  logic rst_sync_b;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b   <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0]        ctrl_reg;
  logic [31:0]        mc_cfg_reg  [NUM_MC];
  logic [PT_W-1:0]    pt_true_reg [NUM_PT];
  logic [PT_W-1:0]    pt_comp_reg [NUM_PT];
  logic [MEM_DW-1:0]  mem_reg     [2**MEM_AW];
  logic [NUM_MC-1:0]  mc_out_reg;
  logic [NUM_MC-1:0]  mc_next;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic        acc;
  logic        wr_go;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_mc;
  logic        hit_pt;
  logic        bad_addr;
  logic [3:0]  mc_idx;
  logic [4:0]  pt_idx;
  logic [1:0]  pt_word;
  logic [31:0] rd_val;

  assign acc      = psel_i & penable_i;
  assign hit_ctrl = paddr_i == OFS_CTRL;
  assign hit_stat = paddr_i == OFS_STAT;
  assign hit_mc   = paddr_i[11:6] == OFS_MC_BASE[11:6]
                  && paddr_i[1:0] == 2'h0;
  assign hit_pt   = paddr_i[11:9] == OFS_PT_BASE[11:9]
                  && paddr_i[1:0] == 2'h0;
  // Status is read-only, so a write there is refused
  assign bad_addr = !(hit_ctrl || hit_mc || hit_pt
                      || (hit_stat && !pwrite_i));
  assign mc_idx   = paddr_i[5:2];
  assign pt_idx   = paddr_i[8:4];
  assign pt_word  = paddr_i[3:2];
  assign wr_go    = acc & pready_reg & pwrite_i & ~pslverr_reg;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_val = ctrl_reg;
    end else if (hit_stat) begin
      rd_val[NUM_MC-1:0]  = mc_out_reg;
      rd_val[STAT_MEM_BIT] = ctrl_reg[CTRL_MEM_BIT];
    end else if (hit_mc) begin
      rd_val = mc_cfg_reg[mc_idx];
    end else if (hit_pt) begin
      case (pt_word)
        2'h0:    rd_val = pt_true_reg[pt_idx][31:0];
        2'h1:    rd_val[PT_W-33:0] = pt_true_reg[pt_idx][PT_W-1:32];
        2'h2:    rd_val = pt_comp_reg[pt_idx][31:0];
        default: rd_val[PT_W-33:0] = pt_comp_reg[pt_idx][PT_W-1:32];
      endcase
    end
  end

  // One wait state keeps read data straight from a flip-flop
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (acc && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= bad_addr;
      prdata_reg  <= (pwrite_i || bad_addr) ? 32'h0000_0000 : rd_val;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  // R1: mode and block controls
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_go && hit_ctrl) begin
      ctrl_reg <= pwdata_i;
    end
  end

  // R5: per macrocell configuration
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < NUM_MC; i++) begin
        mc_cfg_reg[i] <= MC_RST;
      end
    end else if (wr_go && hit_mc) begin
      mc_cfg_reg[mc_idx] <= pwdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < NUM_PT; i++) begin
        pt_true_reg[i] <= PT_RST;
        pt_comp_reg[i] <= PT_RST;
      end
    end else if (wr_go && hit_pt) begin
      case (pt_word)
        2'h0:    pt_true_reg[pt_idx][31:0] <= pwdata_i;
        2'h1:    pt_true_reg[pt_idx][PT_W-1:32] <= pwdata_i[PT_W-33:0];
        2'h2:    pt_comp_reg[pt_idx][31:0] <= pwdata_i;
        default: pt_comp_reg[pt_idx][PT_W-1:32] <= pwdata_i[PT_W-33:0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block clocks, enables and clears
  logic [1:0] bclk;
  logic [1:0] bclk_prev_reg;
  logic [1:0] tick;
  logic [1:0] clr_eff;

  for (genvar k = 0; k < 2; k++) begin : g_ctl
    logic [1:0] src;
    logic       raw_clr;
    assign src = ctrl_reg[CTRL_CLK_SRC_LSB + 2*k +: 2];
    // R10: clock source pick
    assign bclk[k] = (src == SRC_GLB) ? glb_sig_i[GLB_CLK_LSB + k]
                   : (src == SRC_LCL) ? lcl_ctrl_i[LCL_CLK_LSB + k]
                   : ded_clk_i[k];
    // R12: edge per block clock
    // R11: enable gates the tick
    assign tick[k] = lcl_ctrl_i[LCL_EN_LSB + k]
                   & (ctrl_reg[CTRL_FALL_LSB + k]
                      ? (bclk_prev_reg[k] & ~bclk[k])
                      : (~bclk_prev_reg[k] & bclk[k]));
    // R13: clear source and inversion
    assign raw_clr = ctrl_reg[CTRL_CLR_LCL_LSB + k]
                   ? lcl_ctrl_i[LCL_CLR_LSB + k]
                   : glb_sig_i[GLB_CLR_LSB + k];
    assign clr_eff[k] = raw_clr ^ ctrl_reg[CTRL_CLR_INV_LSB + k];
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bclk_prev_reg <= 2'h0;
    end else begin
      bclk_prev_reg <= bclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Product terms
  // R2: logic inputs
  // R3: feedback lines
  logic [PT_W-1:0]   lit;
  logic [NUM_PT-1:0] pt;
  logic [NUM_MC-1:0] lend_vec;

  assign lit = {mc_out_reg[NUM_FB-1:0], lgc_in_i};

  for (genvar p = 0; p < NUM_PT; p++) begin : g_pt
    // An empty mask leaves the term constantly true
    assign pt[p] = (&(~pt_true_reg[p] | lit))
                 & (&(~pt_comp_reg[p] | ~lit));
  end

  ////////////////////////////////////////////////////////////////////////
  // Macrocells
  // R4: sixteen macrocells
  for (genvar g = 0; g < NUM_MC; g++) begin : g_mc
    localparam logic [NUM_MC-1:0] SELF = 16'h0001 << g;
    logic [31:0]       cfg;
    logic              pt0;
    logic              pt1;
    logic              two_in;
    logic              prim;
    logic              borrowed;
    logic              fval;
    logic              clr;
    logic              q;
    logic [1:0]        clr_sel;

    assign cfg = mc_cfg_reg[g];
    assign pt0 = pt[2*g];
    // R7: optional inversion
    assign pt1 = pt[2*g+1] ^ cfg[MC_INV1_BIT];
    assign two_in = cfg[MC_TYPE_LSB + 1];
    // R6: lend or use
    assign lend_vec[g] = (cfg[MC_LEND0_BIT] & pt0)
                       | (cfg[MC_LEND1_BIT] & pt1);
    // JK and SR take the second term as their second input
    assign prim = (~cfg[MC_LEND0_BIT] & pt0)
                | (~cfg[MC_LEND1_BIT] & ~two_in & pt1);
    // R15: borrowed terms
    // R16: one set per neighbour
    // One wide OR over all lenders, same depth however many sets are borrowed
    assign borrowed = |(cfg[MC_BORROW_LSB +: NUM_MC] & ~SELF & lend_vec);
    assign fval = (prim | borrowed) ^ cfg[MC_XOR_BIT];
    assign clr_sel = cfg[MC_CLR_LSB +: 2];
    // R14: per cell clear pick
    assign clr = (clr_sel == CLR_ZERO) ? clr_eff[0]
               : (clr_sel == CLR_ONE)  ? clr_eff[1]
               : 1'b0;

    // R11: cell tick from its clock
    ptm_mc_reg u_reg (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_sync_b),
      .tick_i    (tick[cfg[MC_CLK_BIT]]),
      .clr_i     (clr),
      .ff_type_i (cfg[MC_TYPE_LSB +: 2]),
      .d_i       (fval),
      .aux_i     (pt1),
      .q_o       (q)
    );

    // R9: bypass path
    assign mc_next[g] = cfg[MC_BYP_BIT] ? fval : q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory operation
  logic [MEM_AW-1:0] wa_reg;
  logic [MEM_AW-1:0] ra_reg;
  logic [MEM_DW-1:0] wd_reg;
  logic [MEM_DW-1:0] rd_reg;
  logic              wr_pend_reg;
  logic              mem_mode;

  assign mem_mode = ctrl_reg[CTRL_MEM_BIT];

  // R17: write side input registers
  // R18: block clock zero writes
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wa_reg      <= 4'h0;
      wd_reg      <= 16'h0000;
      wr_pend_reg <= 1'b0;
    end else if (mem_mode && tick[0]) begin
      wa_reg      <= lgc_in_i[MEM_WA_LSB +: MEM_AW];
      wd_reg      <= lgc_in_i[MEM_WD_LSB +: MEM_DW];
      wr_pend_reg <= lgc_in_i[MEM_WE_BIT];
    end else begin
      wr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      for (int i = 0; i < 2**MEM_AW; i++) begin
        mem_reg[i] <= 16'h0000;
      end
    end else if (wr_pend_reg) begin
      mem_reg[wa_reg] <= wd_reg;
    end
  end

  // R18: block clock one reads
  // R17: optional output register
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ra_reg <= 4'h0;
      rd_reg <= 16'h0000;
    end else if (mem_mode && tick[1]) begin
      ra_reg <= lgc_in_i[MEM_RA_LSB +: MEM_AW];
      rd_reg <= mem_reg[ra_reg];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output stage
  // R1: mode select
  always_ff @(posedge clk_sys_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mc_out_reg <= 16'h0000;
    end else if (mem_mode) begin
      mc_out_reg <= ctrl_reg[CTRL_OREG_BIT] ? rd_reg : mem_reg[ra_reg];
    end else begin
      mc_out_reg <= mc_next;
    end
  end

  assign mc_out_o = mc_out_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ready_cause;
    @(posedge clk_sys_i) disable iff (!rst_sync_b)
      pready_o |-> $past(psel_i && penable_i) ##1 !pready_o;
  endproperty
  a_ready_cause: assert property (p_ready_cause) // R1
    else $error("pready without an access phase");

  property p_bad_addr;
    @(posedge clk_sys_i) disable iff (!rst_sync_b)
      acc && !pready_reg && bad_addr |=> pready_o && pslverr_o;
  endproperty
  a_bad_addr: assert property (p_bad_addr) // R1
    else $error("unmapped access not flagged");

  property p_ctrl_write;
    @(posedge clk_sys_i) disable iff (!rst_sync_b)
      wr_go && hit_ctrl |=> ctrl_reg == $past(pwdata_i);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // R1
    else $error("control write lost");

  property p_mem_write;
    @(posedge clk_sys_i) disable iff (!rst_sync_b)
      mem_mode && tick[0] && lgc_in_i[MEM_WE_BIT]
        ##1 wr_pend_reg |=> mem_reg[$past(wa_reg)] == $past(wd_reg);
  endproperty
  a_mem_write: assert property (p_mem_write) // R17
    else $error("registered write did not reach storage");

  property p_oreg_hold;
    @(posedge clk_sys_i) disable iff (!rst_sync_b)
      (mem_mode && ctrl_reg[CTRL_OREG_BIT] && !tick[1])
        ##1 (mem_mode && ctrl_reg[CTRL_OREG_BIT] && !tick[1])
        |=> $stable(mc_out_o);
  endproperty
  a_oreg_hold: assert property (p_oreg_hold) // R18
    else $error("registered read output moved without a tick");

  c_apb_write: cover property (@(posedge clk_sys_i) wr_go);
  c_mem_write: cover property (@(posedge clk_sys_i) wr_pend_reg);
  c_tick_fall: cover property (@(posedge clk_sys_i)
                 tick[1] && ctrl_reg[CTRL_FALL_LSB + 1]);
  c_slverr:    cover property (@(posedge clk_sys_i) pslverr_o);

endmodule : ptm_macrocell_array

// >>> bench/ptm_lcl_model.sv
`timescale 1ns/1ps
// Far side: neighbouring cluster and local routing lines
module ptm_lcl_model
  import ptm_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Lines into the block
  output logic      [31:0] lgc_in_o,
  output logic      [1:0]  ded_clk_o,
  output logic      [3:0]  glb_sig_o,
  output logic      [5:0]  lcl_ctrl_o
);
  // Clock lines stand still between ticks
  initial begin
    lgc_in_o   = 32'h0;
    ded_clk_o  = 2'h0;
    glb_sig_o  = 4'h0;
    lcl_ctrl_o = 6'h0;
  end
  //////////////////////////////////////////
  // literal inputs
  task automatic set_in(input logic [31:0] v);
    @(posedge clk_i);
    lgc_in_o <= v;
  endtask : set_in
  // pin, global or local clock source
  task automatic clk_line(input int k, input int src, input logic lvl);
    @(posedge clk_i);
    if (src == 1)
      glb_sig_o[k] <= lvl;
    else if (src == 2)
      lcl_ctrl_o[k] <= lvl;
    else
      ded_clk_o[k] <= lvl;
    // Slow source: level held well past any sampling stage
    repeat (6) @(posedge clk_i);
  endtask : clk_line
  task automatic set_en(input int k, input logic v);
    @(posedge clk_i);
    lcl_ctrl_o[2+k] <= v;
  endtask : set_en
  task automatic set_clr(input int k, input int lcl, input logic v);
    @(posedge clk_i);
    if (lcl != 0)
      lcl_ctrl_o[4+k] <= v;
    else
      glb_sig_o[2+k] <= v;
    repeat (4) @(posedge clk_i);
  endtask : set_clr
endmodule : ptm_lcl_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ptm_pkg::*;
;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lgc_in, rd;
  logic [1:0]  ded_clk;
  logic [3:0]  glb_sig;
  logic [5:0]  lcl_ctrl;
  logic [15:0] mc_out;
  logic        er, e;
  int          error_cnt, cmp_count;
  logic [31:0] cfgs [3] = '{32'h20, 32'h24, 32'h220};
  int          bsel [4] = '{10, 11, 13, 14};
  // Per step: type, K, J, expected q
  logic [4:0]  steps [13] = '{5'h03, 5'h00, 5'h0b, 5'h0a, 5'h08, 5'h13,
    5'h16, 5'h14, 5'h17, 5'h1b, 5'h1e, 5'h1b, 5'h1c};
  ptm_macrocell_array u_ptm_macrocell_array (
    .clk_sys_i(clk_sys), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .lgc_in_i(lgc_in), .ded_clk_i(ded_clk),
    .glb_sig_i(glb_sig), .lcl_ctrl_i(lcl_ctrl), .mc_out_o(mc_out));
  ptm_lcl_model u_ptm_lcl_model (
    .clk_i(clk_sys), .lgc_in_o(lgc_in), .ded_clk_o(ded_clk),
    .glb_sig_o(glb_sig), .lcl_ctrl_o(lcl_ctrl));
  //////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      chk(32'(pready), 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
    chk(32'(er), 32'(xe));
  endtask : rdc
  task automatic mc_cfg(input int m, input logic [31:0] v);
    apb(1'b1, OFS_MC_BASE + 12'(4 * m), v);
  endtask : mc_cfg
  task automatic set_pt(input int p, input logic [31:0] lo,
                        input logic [31:0] hi);
    apb(1'b1, OFS_PT_BASE + 12'(16 * p), lo);
    apb(1'b1, OFS_PT_BASE + 12'(16 * p + 4), hi);
  endtask : set_pt
  task automatic tick(input int k, input int src);
    u_ptm_lcl_model.clk_line(k, src, 1'b1);
    u_ptm_lcl_model.clk_line(k, src, 1'b0);
  endtask : tick
  task automatic in_wait(input logic [31:0] v);
    u_ptm_lcl_model.set_in(v);
    repeat (4) @(posedge clk_sys);
  endtask : in_wait
  //////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(OFS_CTRL, CTRL_RST, 1'b0);
    rdc(OFS_MC_BASE, MC_RST, 1'b0);
    rdc(OFS_MC_BASE + 12'h03c, MC_RST, 1'b0);
    rdc(OFS_MC_BASE + 12'h040, 32'h0, 1'b0 | 1'b1);
    // Combinational cell: plain, inverted term, inverted output
    set_pt(0, 32'h8, 32'h0);
    set_pt(1, 32'h20, 32'h0);
    for (int c = 0; c < 3; c++) begin
      mc_cfg(0, cfgs[c]);
      for (int i = 0; i < 4; i++) begin
        in_wait({26'h0, i[1], 1'b0, i[0], 3'h0});
        e = (c == 1) ? (i[0] | ~i[1]) : (i[0] | i[1]);
        chk(32'(mc_out[0]), 32'(e ^ (c == 2)));
      end
    end
    // Borrowed sets from the nearest and the farthest cell
    mc_cfg(1, 32'h23);
    mc_cfg(15, 32'h23);
    set_pt(2, 32'h400, 32'h0);
    set_pt(3, 32'h800, 32'h0);
    set_pt(30, 32'h2000, 32'h0);
    set_pt(31, 32'h4000, 32'h0);
    mc_cfg(0, 32'h8002_0020);
    for (int i = 0; i < 4; i++) begin
      in_wait(32'h1 << bsel[i]);
      chk(32'(mc_out[0]), 32'h1);
    end
    mc_cfg(0, 32'h20);
    in_wait(32'h4000);
    chk(32'(mc_out[0]), 32'h0);
    // Ninth output feeds the next cell
    set_pt(16, 32'h8, 32'h0);
    set_pt(17, 32'h8000_0000, 32'h0);
    set_pt(18, 32'h0, 32'h100);
    set_pt(19, 32'h8000_0000, 32'h0);
    for (int i = 0; i < 2; i++) begin
      in_wait(i[0] ? 32'h8 : 32'h0);
      chk(32'(mc_out[9]), 32'(i[0]));
    end
    // Register types on block clock 0
    apb(1'b1, OFS_CTRL, 32'h100);
    set_pt(6, 32'h1000, 32'h0);
    set_pt(7, 32'h2000, 32'h0);
    u_ptm_lcl_model.set_en(0, 1'b1);
    for (int i = 0; i < 13; i++) begin
      mc_cfg(3, {27'h0, steps[i][4:3], 3'h0});
      u_ptm_lcl_model.set_in({18'h0, steps[i][2:1], 12'h0});
      tick(0, 1);
      chk(32'(mc_out[3]), 32'(steps[i][0]));
    end
    mc_cfg(3, 32'h0);
    u_ptm_lcl_model.set_in(32'h1000);
    u_ptm_lcl_model.set_en(0, 1'b0);
    tick(0, 1);
    chk(32'(mc_out[3]), 32'h0);
    u_ptm_lcl_model.set_en(0, 1'b1);
    // Every clock source, code 3 falls back to the pin
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CTRL, 32'(s) << 8);
      u_ptm_lcl_model.set_in(s[0] ? 32'h1000 : 32'h0);
      tick(0, s);
      chk(32'(mc_out[3]), 32'(s[0]));
    end
    // Block clock 1 on its falling edge
    apb(1'b1, OFS_CTRL, 32'h408);
    mc_cfg(3, 32'h40);
    u_ptm_lcl_model.set_en(1, 1'b1);
    u_ptm_lcl_model.set_in(32'h0);
    u_ptm_lcl_model.clk_line(1, 1, 1'b1);
    chk(32'(mc_out[3]), 32'h1);
    u_ptm_lcl_model.clk_line(1, 1, 1'b0);
    chk(32'(mc_out[3]), 32'h0);
    // Clear selection, inversion and local source
    apb(1'b1, OFS_CTRL, 32'h100);
    mc_cfg(3, 32'h80);
    u_ptm_lcl_model.set_in(32'h1000);
    tick(0, 1);
    u_ptm_lcl_model.set_clr(0, 0, 1'b1);
    chk(32'(mc_out[3]), 32'h0);
    u_ptm_lcl_model.set_clr(0, 0, 1'b0);
    mc_cfg(3, 32'h100);
    tick(0, 1);
    chk(32'(mc_out[3]), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h120);
    repeat (3) @(posedge clk_sys);
    chk(32'(mc_out[3]), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h180);
    tick(0, 1);
    chk(32'(mc_out[3]), 32'h1);
    u_ptm_lcl_model.set_clr(1, 1, 1'b1);
    chk(32'(mc_out[3]), 32'h0);
    // Memory operation: write on clock 0, read on clock 1
    apb(1'b1, OFS_CTRL, 32'h501);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h1_0000, 32'h1_0000);
    u_ptm_lcl_model.set_in(32'h01be_ef05);
    tick(0, 1);
    u_ptm_lcl_model.set_in(32'h0000_0050);
    tick(1, 1);
    chk(32'(mc_out), 32'h0000_beef);
    // Output register shows the older read until the next read tick
    apb(1'b1, OFS_CTRL, 32'h503);
    repeat (3) @(posedge clk_sys);
    chk(32'(mc_out), 32'h0);
    tick(1, 1);
    chk(32'(mc_out), 32'h0000_beef);
    // Status is read-only: a write is refused
    apb(1'b1, OFS_STAT, 32'hffff_ffff);
    chk(32'(er), 32'h1);
    give_verdict();
  end
endmodule : tb_top
